/* File: verif/lsr_ctl_model.sv */
// Remote controller model that issues filter writes and queries.
`timescale 1ns/10ps
`default_nettype none
module lsr_ctl_model (
    input  wire logic        mclk,
    input  wire logic        rd_valid,
    input  wire logic [14:0] rd_val,
    output logic             wr_en,
    output logic             rd_en,
    output logic [1:0]       sel,
    output logic [1:0]       bound,
    output logic [14:0]      wr_val
);
    initial begin
        wr_en  = 1'b0;
        rd_en  = 1'b0;
        sel    = 2'h0;
        bound  = 2'h0;
        wr_val = 15'h5555;
    end
    // Sends a weighted integer, or a range keyword when bnd is 1 or 2.
    task automatic write(input logic [1:0] s, input logic [1:0] bnd, input logic [14:0] v);
        @(posedge mclk);
        wr_en  <= 1'b1;
        sel    <= s;
        bound  <= bnd;
        wr_val <= v;
        @(posedge mclk);
        wr_en  <= 1'b0;
        sel    <= ~s;
        wr_val <= ~v;
    endtask
    // Issues one query and waits a bounded time for the answer.
    task automatic query(input logic [1:0] s, output logic [14:0] v, output bit ok);
        @(posedge mclk);
        rd_en <= 1'b1;
        sel   <= s;
        @(posedge mclk);
        rd_en <= 1'b0;
        sel   <= ~s;
        wait_answer(v, ok);
    endtask
    // Writes a filter and queries it on the very next cycle.
    task automatic write_query(input logic [1:0] s, input logic [14:0] wv,
                               output logic [14:0] v, output bit ok);
        @(posedge mclk);
        wr_en  <= 1'b1;
        sel    <= s;
        bound  <= 2'h0;
        wr_val <= wv;
        @(posedge mclk);
        wr_en  <= 1'b0;
        rd_en  <= 1'b1;
        @(posedge mclk);
        rd_en  <= 1'b0;
        sel    <= ~s;
        wr_val <= ~wv;
        wait_answer(v, ok);
    endtask
    // Samples the answer at the edges after the query edge, a bounded number of times.
    task automatic wait_answer(output logic [14:0] v, output bit ok);
        ok = 1'b0;
        v  = 15'h0000;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge mclk);
            if (rd_valid === 1'b1) begin
                ok = 1'b1;
                v  = rd_val;
            end
        end
    endtask
endmodule
`default_nettype wire

/* File: verif/lsr_top_test.sv */
// Self-checking testbench for the limit status register set.
`timescale 1ns/10ps
`default_nettype none
`include "lsr_cfg.svh"
module lsr_top_test;
    logic        mclk, rst_n, preset, wr_en, rd_en, rd_valid;
    logic [1:0]  sel, bound;
    logic [14:0] lim_cond, wr_val, rd_val, que_neg_filt;
    logic [14:0] fv [1:3] = '{15'h000C, 15'h0003, 15'h4008};
    int          n_errors = 0;
    int          checked = 0;
    initial mclk = 1'b0;
    always #5 mclk = ~mclk;
    lsr_top #(.W(15)) u_lsr_top (.mclk(mclk), .rst_n(rst_n), .preset(preset),
        .lim_cond(lim_cond), .wr_en(wr_en), .rd_en(rd_en), .sel(sel), .bound(bound),
        .wr_val(wr_val), .rd_val(rd_val), .rd_valid(rd_valid), .que_neg_filt(que_neg_filt));
    lsr_ctl_model u_lsr_ctl_model (.mclk(mclk), .rd_valid(rd_valid), .rd_val(rd_val),
        .wr_en(wr_en), .rd_en(rd_en), .sel(sel), .bound(bound), .wr_val(wr_val));
    task automatic print_verdict();
        $display("errors=%0d checks=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [14:0] exp, input logic [14:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic rd_cmp(input logic [1:0] s, input logic [14:0] exp);
        logic [14:0] v;
        bit          ok;
        u_lsr_ctl_model.query(s, v, ok);
        if (!ok) begin
            n_errors++;
            print_verdict();
        end else begin
            cmp(exp, v);
        end
    endtask
    task automatic wq_cmp(input logic [1:0] s, input logic [14:0] wv);
        logic [14:0] v;
        bit          ok;
        u_lsr_ctl_model.write_query(s, wv, v, ok);
        if (!ok) begin
            n_errors++;
            print_verdict();
        end else begin
            cmp(wv, v);
        end
    endtask
    task automatic t_filters();
        for (int s = 0; s < 4; s++) rd_cmp(2'(s), 15'h0000);
        for (int s = 1; s < 4; s++) begin
            u_lsr_ctl_model.write(2'(s), `LSR_BND_NONE, fv[s]);
            rd_cmp(2'(s), fv[s]);
            u_lsr_ctl_model.write(2'(s), `LSR_BND_MAX, 15'h0001);
            rd_cmp(2'(s), `LSR_VAL_MAX);
            u_lsr_ctl_model.write(2'(s), `LSR_BND_MIN, 15'h0001);
            rd_cmp(2'(s), `LSR_VAL_MIN);
            u_lsr_ctl_model.write(2'(s), 2'h3, fv[s]);
            rd_cmp(2'(s), fv[s]);
        end
        cmp(fv[3], que_neg_filt);
        wq_cmp(`LSR_SEL_QUE_NEG, 15'h2AAA);
        cmp(15'h2AAA, que_neg_filt);
        u_lsr_ctl_model.write(`LSR_SEL_QUE_NEG, `LSR_BND_NONE, fv[3]);
        u_lsr_ctl_model.write(`LSR_SEL_LIM_EVT, `LSR_BND_NONE, 15'h7FFF);
        rd_cmp(`LSR_SEL_LIM_EVT, 15'h0000);
    endtask
    task automatic t_preset();
        preset <= 1'b1;
        repeat (3) @(posedge mclk);
        preset <= 1'b0;
        for (int s = 1; s < 4; s++) rd_cmp(2'(s), fv[s]);
        cmp(fv[3], que_neg_filt);
    endtask
    task automatic t_events();
        lim_cond <= 15'h0005;
        repeat (3) @(posedge mclk);
        rd_cmp(`LSR_SEL_LIM_EVT, 15'h0001);
        rd_cmp(`LSR_SEL_LIM_EVT, 15'h0000);
        lim_cond <= 15'h0000;
        repeat (3) @(posedge mclk);
        fork
            rd_cmp(`LSR_SEL_LIM_EVT, 15'h0004);
            begin
                @(posedge mclk);
                lim_cond <= 15'h0002;
            end
        join
        rd_cmp(`LSR_SEL_LIM_EVT, 15'h0002);
    endtask
    initial begin
        rst_n = 1'b0;
        preset = 1'b0;
        lim_cond = 15'h0000;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        t_filters();
        t_preset();
        t_events();
        print_verdict();
    end
    initial begin
        #200000;
        n_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire

/* File: verilog/lsr_cfg.svh */
// Constants for the limit status register set.
`ifndef LSR_CFG_SVH
`define LSR_CFG_SVH
`define LSR_REG_W        15
`define LSR_VAL_MAX      15'h7FFF
`define LSR_VAL_MIN      15'h0000
`define LSR_FILT_RST     15'h0000
`define LSR_EVT_RST      15'h0000
`define LSR_SEL_W        2
`define LSR_SEL_LIM_EVT  2'h0
`define LSR_SEL_LIM_NEG  2'h1
`define LSR_SEL_LIM_POS  2'h2
`define LSR_SEL_QUE_NEG  2'h3
`define LSR_BND_NONE     2'h0
`define LSR_BND_MAX      2'h1
`define LSR_BND_MIN      2'h2
`endif

/* File: verilog/lsr_edge_detect.sv */
// Per-bit transition filter that raises event pulses.
`timescale 1ns/10ps
`default_nettype none
module lsr_edge_detect #(
    parameter int W = 15
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] cond,
    input  wire logic [W-1:0] rise_en,
    input  wire logic [W-1:0] fall_en,
    output logic      [W-1:0] hit
);
    logic [W-1:0] prev;
    logic [W-1:0] next_prev;

    always_comb begin
        next_prev = cond;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prev <= '0;
        end else begin
            prev <= next_prev;
        end
    end

    // ****************************************
    // Edge qualification
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            assign hit[i] = (rise_en[i] & cond[i] & ~prev[i])
                          | (fall_en[i] & ~cond[i] & prev[i]);
        end
    endgenerate
endmodule
`default_nettype wire

/* File: verilog/lsr_pkg.sv */
// Types for the limit status register set.
`default_nettype none
package lsr_pkg;
    typedef enum logic [1:0] {
        LSR_LIM_EVT = 2'h0,
        LSR_LIM_NEG = 2'h1,
        LSR_LIM_POS = 2'h2,
        LSR_QUE_NEG = 2'h3
    } lsr_sel_t;
endpackage
`default_nettype wire

/* File: verilog/lsr_top.sv */
// Limit failure status register set with its filter registers.
`timescale 1ns/10ps
`default_nettype none
`include "lsr_cfg.svh"
module lsr_top #(
    parameter int W = `LSR_REG_W
) (
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    input  wire logic                   preset,
    input  wire logic [W-1:0]           lim_cond,
    input  wire logic                   wr_en,
    input  wire logic                   rd_en,
    input  wire logic [`LSR_SEL_W-1:0]  sel,
    input  wire logic [1:0]             bound,
    input  wire logic [W-1:0]           wr_val,
    output logic      [W-1:0]           rd_val,
    output logic                        rd_valid,
    output logic      [W-1:0]           que_neg_filt
);
    logic [W-1:0] lim_evt;
    logic [W-1:0] lim_neg;
    logic [W-1:0] lim_pos;
    logic [W-1:0] que_neg;
    logic [W-1:0] next_lim_evt;
    logic [W-1:0] next_lim_neg;
    logic [W-1:0] next_lim_pos;
    logic [W-1:0] next_que_neg;
    logic [W-1:0] next_rd_val;
    logic         next_rd_valid;
    logic [W-1:0] hit;
    logic [W-1:0] load_val;

    // ****************************************
    // Write value resolution
    // ****************************************
    function automatic logic [W-1:0] resolve(input logic [1:0] b, input logic [W-1:0] v);
        logic [W-1:0] r;
        r = v;
        if (b == `LSR_BND_MAX) begin
            r = W'(`LSR_VAL_MAX);
        end else if (b == `LSR_BND_MIN) begin
            r = W'(`LSR_VAL_MIN);
        end
        return r;
    endfunction

    lsr_edge_detect #(.W(W)) u_edge (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .cond    (lim_cond),
        .rise_en (lim_pos),
        .fall_en (lim_neg),
        .hit     (hit)
    );

    // ****************************************
    // Register next state
    // ****************************************
    always_comb begin
        load_val      = resolve(bound, wr_val);
        next_lim_neg  = lim_neg;
        next_lim_pos  = lim_pos;
        next_que_neg  = que_neg;
        next_lim_evt  = lim_evt;
        next_rd_val   = rd_val;
        next_rd_valid = 1'b0;
        if (wr_en) begin
            unique case (lsr_pkg::lsr_sel_t'(sel))
                lsr_pkg::LSR_LIM_NEG: next_lim_neg = load_val;
                lsr_pkg::LSR_LIM_POS: next_lim_pos = load_val;
                lsr_pkg::LSR_QUE_NEG: next_que_neg = load_val;
                lsr_pkg::LSR_LIM_EVT: next_lim_neg = lim_neg;
            endcase
        end
        if (rd_en) begin
            next_rd_valid = 1'b1;
            unique case (lsr_pkg::lsr_sel_t'(sel))
                lsr_pkg::LSR_LIM_EVT: begin
                    next_rd_val  = lim_evt;
                    next_lim_evt = '0;
                end
                lsr_pkg::LSR_LIM_NEG: next_rd_val = lim_neg;
                lsr_pkg::LSR_LIM_POS: next_rd_val = lim_pos;
                lsr_pkg::LSR_QUE_NEG: next_rd_val = que_neg;
            endcase
        end
        next_lim_evt = next_lim_evt | hit;
    end

    // Preset is deliberately not an input to the filter registers.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            lim_evt  <= W'(`LSR_EVT_RST);
            lim_neg  <= W'(`LSR_FILT_RST);
            lim_pos  <= W'(`LSR_FILT_RST);
            que_neg  <= W'(`LSR_FILT_RST);
            rd_val   <= '0;
            rd_valid <= 1'b0;
        end else begin
            lim_evt  <= next_lim_evt;
            lim_neg  <= next_lim_neg;
            lim_pos  <= next_lim_pos;
            que_neg  <= next_que_neg;
            rd_val   <= next_rd_val;
            rd_valid <= next_rd_valid;
        end
    end

    assign que_neg_filt = que_neg;

    // ****************************************
    // Checks
    // ****************************************
    a_evt_read_value: assert property (@(posedge mclk) disable iff (!rst_n)
        rd_en && sel == `LSR_SEL_LIM_EVT |=> rd_valid && rd_val == $past(lim_evt))
        else $error("Event read value wrong.");
    a_evt_read_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        rd_en && sel == `LSR_SEL_LIM_EVT |=> lim_evt == $past(hit))
        else $error("Event register not cleared by read.");
    a_neg_write_load: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_en && sel == `LSR_SEL_LIM_NEG && bound == `LSR_BND_NONE
        |=> lim_neg == $past(wr_val))
        else $error("Limit falling filter not loaded.");
    a_pos_write_load: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_en && sel == `LSR_SEL_LIM_POS && bound == `LSR_BND_NONE
        |=> lim_pos == $past(wr_val))
        else $error("Limit rising filter not loaded.");
    a_que_write_read: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_en && sel == `LSR_SEL_QUE_NEG && bound == `LSR_BND_NONE
        ##1 rd_en && sel == `LSR_SEL_QUE_NEG
        |=> rd_val == $past(wr_val, 2))
        else $error("Summary filter read back wrong.");
    a_bound_max_load: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_en && sel == `LSR_SEL_LIM_POS && bound == `LSR_BND_MAX
        |=> lim_pos == W'(`LSR_VAL_MAX))
        else $error("Maximum keyword not applied.");
    a_filt_read_value: assert property (@(posedge mclk) disable iff (!rst_n)
        rd_en && sel == `LSR_SEL_LIM_NEG |=> rd_val == $past(lim_neg))
        else $error("Filter query value wrong.");
    a_preset_keeps: assert property (@(posedge mclk) disable iff (!rst_n)
        preset && !wr_en |=> $stable(lim_neg) && $stable(lim_pos) && $stable(que_neg))
        else $error("Preset altered a filter register.");
    a_edge_sets_evt: assert property (@(posedge mclk) disable iff (!rst_n)
        hit != '0 |=> (lim_evt & $past(hit)) == $past(hit))
        else $error("Qualified edge did not set event.");
    a_evt_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
        !(rd_en && sel == `LSR_SEL_LIM_EVT) |=> (lim_evt & $past(lim_evt)) == $past(lim_evt))
        else $error("Event bit lost without a read.");
    a_pos_read_value: assert property (@(posedge mclk) disable iff (!rst_n)
        rd_en && sel == `LSR_SEL_LIM_POS |=> rd_val == $past(lim_pos))
        else $error("Rising filter query value wrong.");
    a_que_read_value: assert property (@(posedge mclk) disable iff (!rst_n)
        rd_en && sel == `LSR_SEL_QUE_NEG |=> rd_val == $past(que_neg))
        else $error("Summary filter query value wrong.");
    a_que_write_load: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_en && sel == `LSR_SEL_QUE_NEG && bound == `LSR_BND_NONE
        |=> que_neg == $past(wr_val))
        else $error("Summary filter not loaded.");
    a_neg_max_load: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_en && sel == `LSR_SEL_LIM_NEG && bound == `LSR_BND_MAX
        |=> lim_neg == W'(`LSR_VAL_MAX))
        else $error("Maximum keyword not applied to falling filter.");
    a_neg_min_load: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_en && sel == `LSR_SEL_LIM_NEG && bound == `LSR_BND_MIN
        |=> lim_neg == W'(`LSR_VAL_MIN))
        else $error("Minimum keyword not applied to falling filter.");
    a_pos_min_load: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_en && sel == `LSR_SEL_LIM_POS && bound == `LSR_BND_MIN
        |=> lim_pos == W'(`LSR_VAL_MIN))
        else $error("Minimum keyword not applied to rising filter.");
    a_que_max_load: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_en && sel == `LSR_SEL_QUE_NEG && bound == `LSR_BND_MAX
        |=> que_neg == W'(`LSR_VAL_MAX))
        else $error("Maximum keyword not applied to summary filter.");
    a_que_min_load: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_en && sel == `LSR_SEL_QUE_NEG && bound == `LSR_BND_MIN
        |=> que_neg == W'(`LSR_VAL_MIN))
        else $error("Minimum keyword not applied to summary filter.");
    a_neg_value_load: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_en && sel == `LSR_SEL_LIM_NEG && bound != `LSR_BND_MAX && bound != `LSR_BND_MIN
        |=> lim_neg == $past(wr_val))
        else $error("Falling filter value not loaded.");
    a_pos_value_load: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_en && sel == `LSR_SEL_LIM_POS && bound != `LSR_BND_MAX && bound != `LSR_BND_MIN
        |=> lim_pos == $past(wr_val))
        else $error("Rising filter value not loaded.");
    a_que_value_load: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_en && sel == `LSR_SEL_QUE_NEG && bound != `LSR_BND_MAX && bound != `LSR_BND_MIN
        |=> que_neg == $past(wr_val))
        else $error("Summary filter value not loaded.");
    a_valid_after_read: assert property (@(posedge mclk) disable iff (!rst_n)
        rd_en |=> rd_valid)
        else $error("Query answer not flagged valid.");
    a_valid_only_read: assert property (@(posedge mclk) disable iff (!rst_n)
        !rd_en |=> !rd_valid)
        else $error("Valid flag raised without a query.");
    a_answer_holds: assert property (@(posedge mclk) disable iff (!rst_n)
        !rd_en |=> $stable(rd_val))
        else $error("Query answer changed without a query.");
    a_filt_need_write: assert property (@(posedge mclk) disable iff (!rst_n)
        !wr_en |=> $stable(lim_neg) && $stable(lim_pos) && $stable(que_neg))
        else $error("Filter register changed without a write.");
    a_evt_write_refused: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_en && sel == `LSR_SEL_LIM_EVT && !rd_en && hit == '0
        |=> lim_evt == $past(lim_evt))
        else $error("Event register changed by a write.");
    a_evt_needs_edge: assert property (@(posedge mclk) disable iff (!rst_n)
        (lim_evt & ~$past(lim_evt) & ~$past(hit)) == '0)
        else $error("Event bit set without a qualified edge.");
endmodule
`default_nettype wire
